/* File: sim/counter_preset_reset_readback_test.sv */
// Self-checking bench for the counter preset, reset and readback block
`timescale 1ns/1ps
module counter_preset_reset_readback_test;
  import cnt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] sdl = 16'h0000, sdh = 16'h0000, cw = 16'h0000, base = 16'h0000;
  logic [15:0] count_readback_low, count_readback_high;
  logic signed [23:0] present_value, compare_value1, compare_value2;
  logic [2:0] compare_cond1, compare_cond2, m;
  logic range_error, compare_out1, compare_out2, index_pin, ext_pin, count_pulse, count_up, ext;
  logic [23:0] v, u;
  logic [31:0] bw;
  int errors = 0;
  int tests_run = 0;
  int ml[8] = '{1, 4, 5, 6, 2, 3, 7, 0};
  always #10 clk = ~clk;
  counter_preset_reset_readback counter_preset_reset_readback_inst (.clk, .rst,
    .setting_data_low(sdl), .setting_data_high(sdh), .counter_control_word(cw),
    .count_readback_low, .count_readback_high, .index_pin, .ext_pin, .count_pulse, .count_up,
    .present_value, .compare_value1, .compare_value2, .compare_cond1, .compare_cond2,
    .range_error, .compare_out1, .compare_out2);
  encoder_model encoder_model_inst (.clk, .index_pin, .ext_pin, .count_pulse, .count_up);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input int b, input logic [15:0] hi, input logic [15:0] lo);
    sdh = hi;
    sdl = lo;
    cw = base | (16'h0001 << b);
    @(negedge clk);
    cw = base;
    @(negedge clk);
  endtask : cmd
  function automatic logic [31:0] to_bcd(input logic signed [23:0] s);
    int a;
    logic [31:0] r;
    a = (s < 0) ? -int'(s) : int'(s);
    r = (s < 0) ? 32'hf0000000 : 32'h00000000;
    for (int i = 0; i < 7; i++) begin
      r[i*4 +: 4] = 4'(a % 10);
      a = a / 10;
    end
    return r;
  endfunction : to_bcd
  task automatic complete_run;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (200000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    v = 24'($urandom(53));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({count_readback_high, count_readback_low}, {8'h00, present_value});
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 24'h7fffff : (i == 1) ? 24'h800000 : 24'($urandom);
      u = 24'($urandom);
      m = 3'($urandom);
      base = 16'h0008;
      cmd(CW_PV_LOAD, {8'h00, v[23:16]}, v[15:0]);
      chk({8'h00, present_value}, {8'h00, v});
      cmd(CW_READBACK, 16'h0000, 16'h0000);
      chk({count_readback_high, count_readback_low}, {8'h00, v});
      base = 16'h0000;
      cmd(CW_READBACK, 16'h0000, 16'h0000);
      chk({count_readback_high, count_readback_low}, to_bcd(v));
      bw = to_bcd(u);
      cmd(CW_PV_LOAD, bw[31:16], bw[15:0]);
      chk({8'h00, present_value}, {8'h00, u});
      base = 16'h0008;
      cmd(i % 2, {1'b0, m, 4'h0, u[23:16]}, u[15:0]);
      chk(i % 2 ? {5'h00, compare_cond2, compare_value2} : {5'h00, compare_cond1, compare_value1}, {5'h00, m, u});
    end
    $display("preset and readback test done");
    cmd(CW_PV_LOAD, 16'h007f, 16'hffff);
    encoder_model_inst.count(1'b1);
    chk({7'h00, range_error, present_value}, 32'h017fffff);
    cmd(CW_PV_LOAD, 16'h0000, 16'h0010);
    chk({7'h00, range_error, present_value}, 32'h00000010);
    $display("overflow test done");
    cmd(CW_SET1_LOAD, 16'h0000, 16'h0000);
    foreach (ml[k]) begin
      m = 3'(ml[k]);
      ext = m inside {2, 3, 7, 0};
      base = {1'b0, m, 4'h1, m[2] | (m == 3'h0), 7'h08};
      cw = base;
      @(negedge clk);
      encoder_model_inst.drive(1'b0, ext);
      cmd(CW_PV_LOAD, 16'h0000, 16'h0005);
      encoder_model_inst.drive(m[0] | (m == 3'h0), ext);
      repeat (5) @(negedge clk);
      chk({8'h00, present_value}, 32'h5);
      encoder_model_inst.count(1'b1);
      chk({8'h00, present_value}, (m == 3'h0) ? 32'h6 : 32'h0);
      encoder_model_inst.count(1'b1);
      chk({8'h00, present_value}, (m == 3'h0) ? 32'h7 : m[0] ? 32'h1 : 32'h0);
      encoder_model_inst.drive(1'b0, ext);
    end
    $display("reset mode test done");
    complete_run();
  end
endmodule : counter_preset_reset_readback_test
bind counter_preset_reset_readback cprr_monitor cprr_monitor_inst (.clk, .rst,
  .setting_data_low, .setting_data_high, .counter_control_word, .count_readback_low,
  .count_readback_high, .count_pulse, .present_value, .compare_value1, .compare_value2,
  .compare_cond1, .compare_cond2, .range_error, .compare_out1);

/* File: sim/cprr_monitor.sv */
// Port assertions for the counter preset, reset and readback block
`timescale 1ns/1ps
module cprr_monitor
  import cnt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WORD_W-1:0] setting_data_low,
  input wire logic [WORD_W-1:0] setting_data_high,
  input wire logic [WORD_W-1:0] counter_control_word,
  input wire logic [WORD_W-1:0] count_readback_low,
  input wire logic [WORD_W-1:0] count_readback_high,
  input wire logic count_pulse,
  input wire logic signed [VAL_W-1:0] present_value,
  input wire logic signed [VAL_W-1:0] compare_value1,
  input wire logic signed [VAL_W-1:0] compare_value2,
  input wire logic [COND_W-1:0] compare_cond1,
  input wire logic [COND_W-1:0] compare_cond2,
  input wire logic range_error,
  input wire logic compare_out1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [VAL_W-1:0] hexv;
  logic [WORD_W-1:0] cw;
  assign hexv = {setting_data_high[7:0], setting_data_low};
  assign cw = counter_control_word;
  chk_pv_hex_load: assert property ($rose(cw[2]) && cw[3] |=> present_value == $past(hexv))
    else $error("present value load mismatch");
  chk_cmp1_load: assert property ($rose(cw[0]) && cw[3] |=> compare_value1 == $past(hexv)
    && compare_cond1 == $past(setting_data_high[14:12])) else $error("compare 1 load mismatch");
  chk_cmp2_load: assert property ($rose(cw[1]) && cw[3] |=> compare_value2 == $past(hexv)
    && compare_cond2 == $past(setting_data_high[14:12])) else $error("compare 2 load mismatch");
  chk_rb_hex_value: assert property ($rose(cw[6]) && cw[3] |=>
    {count_readback_high, count_readback_low} == {8'h00, $past(present_value)})
    else $error("hex readback mismatch");
  chk_rb_bcd_sign: assert property ($rose(cw[6]) && !cw[3] |=>
    count_readback_high[15:12] == ($past(present_value[23]) ? SIGN_NEG : SIGN_POS))
    else $error("bcd readback sign mismatch");
  chk_no_early_clear: assert property (!$past(rst) && !count_pulse && !$rose(cw[2]) |=>
    $stable(present_value)) else $error("present value moved without a count");
  chk_preset_restart: assert property ($rose(cw[2]) |=> !range_error)
    else $error("preset left counting halted");
  chk_out1_cond: assert property (!$past(rst) |-> compare_out1 == $past(cw[8] &&
    (compare_cond1 == COND_GE ? present_value >= compare_value1 : present_value <= compare_value1)))
    else $error("compare output 1 mismatch");
  cover property ($rose(range_error));
  cover property ($rose(cw[6]) && !cw[3]);
  cover property (count_pulse ##1 present_value == 0);
endmodule : cprr_monitor

/* File: sim/encoder_model.sv */
// Encoder index, external input and count event source
`timescale 1ns/1ps
module encoder_model
  import cnt_pkg::*;
(
  output logic index_pin,
  output logic ext_pin,
  output logic count_pulse,
  output logic count_up,
  input wire logic clk
);
  int idx_quiet = IDX_GAP_CYC;
  int ext_quiet = EXT_GAP_CYC;
  initial begin
    index_pin = 1'b0;
    ext_pin = 1'b0;
    count_pulse = 1'b0;
    count_up = 1'b1;
  end
  always @(posedge clk) begin
    idx_quiet <= index_pin ? 0 : idx_quiet + 1;
    ext_quiet <= ext_pin ? 0 : ext_quiet + 1;
  end
  // Raising an input waits out the least quiet time since its last release
  task automatic drive(input logic idx, input logic ext);
    while ((idx && !index_pin && idx_quiet < IDX_GAP_CYC) || (ext && !ext_pin && ext_quiet < EXT_GAP_CYC)) begin
      @(negedge clk);
    end
    ext_pin = ext;
    index_pin = idx;
  endtask : drive
  task automatic count(input logic up);
    count_up = up;
    count_pulse = 1'b1;
    @(negedge clk);
    count_pulse = 1'b0;
    @(negedge clk);
  endtask : count
endmodule : encoder_model

/* File: src/bcd_codec.sv */
// Conversion between a 24-bit signed value and the signed BCD word pair
`timescale 1ns/1ps
module bcd_codec
  import cnt_pkg::*;
(
  input wire logic signed [VAL_W-1:0] bin_in,
  output logic [2*WORD_W-1:0] bcd_out,
  input wire logic [2*WORD_W-1:0] bcd_in,
  output logic signed [VAL_W-1:0] bin_out
);
  logic [VAL_W-1:0] mag;
  logic [4*BCD_DIGITS-1:0] digs;
  logic [VAL_W-1:0] acc;
  logic [VAL_W-1:0] mag_in;

  // Magnitude to BCD by shift and add three
  always_comb begin
    mag = bin_in[VAL_W-1] ? VAL_W'(-bin_in) : VAL_W'(bin_in);
    digs = '0;
    for (int i = VAL_W - 1; i >= 0; i--) begin
      for (int d = 0; d < BCD_DIGITS; d++) begin
        if (digs[4*d +: 4] > 4'h4) begin
          digs[4*d +: 4] = digs[4*d +: 4] + 4'h3;
        end
      end
      digs = {digs[4*BCD_DIGITS-2:0], mag[i]};
    end
    bcd_out = {(bin_in[VAL_W-1] ? SIGN_NEG : SIGN_POS), digs};
  end

  // BCD to binary, most significant digit first
  always_comb begin
    acc = '0;
    for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
      acc = VAL_W'(acc * 24'd10) + VAL_W'(bcd_in[4*d +: 4]);
    end
    mag_in = acc;
    bin_out = (bcd_in[2*WORD_W-1 -: 4] != SIGN_POS) ? -$signed(mag_in) : $signed(mag_in);
  end
endmodule : bcd_codec

/* File: src/cnt_pkg.sv */
// Constants shared by the counter preset, reset and readback logic
package cnt_pkg;
  localparam int VAL_W = 24;
  localparam int WORD_W = 16;
  localparam int BCD_DIGITS = 7;
  localparam int COND_W = 3;
  localparam int MODE_W = 3;
  // Control word bit positions
  localparam int CW_SET1_LOAD = 0;
  localparam int CW_SET2_LOAD = 1;
  localparam int CW_PV_LOAD = 2;
  localparam int CW_FMT_HEX = 3;
  localparam int CW_READBACK = 6;
  localparam int CW_HOST_RESET = 7;
  localparam int CW_OUT1_EN = 8;
  localparam int CW_OUT2_EN = 9;
  localparam int CW_MODE_LO = 12;
  localparam int CW_MODE_HI = 14;
  // Setting word field positions for compare loads
  localparam int SV_COND_LO = 12;
  localparam int SV_COND_HI = 14;
  localparam int SV_BCD_SIGN = 15;
  localparam int HEX_HIGH_W = 8;
  localparam logic [3:0] SIGN_POS = 4'h0;
  localparam logic [3:0] SIGN_NEG = 4'hf;
  localparam logic [COND_W-1:0] COND_GE = 3'h0;
  // Signed counting range
  localparam logic signed [VAL_W-1:0] PV_MAX = 24'sh7fffff;
  localparam logic signed [VAL_W-1:0] PV_MIN = -24'sh800000;
  localparam logic signed [VAL_W-1:0] PV_RESET = 24'sh000000;
  localparam logic [COND_W-1:0] COND_RESET = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  // Reset modes
  localparam logic [MODE_W-1:0] MODE_NONE = 3'h0;
  localparam logic [MODE_W-1:0] MODE_IDX = 3'h1;
  localparam logic [MODE_W-1:0] MODE_EXT = 3'h2;
  localparam logic [MODE_W-1:0] MODE_IDX_EXT = 3'h3;
  localparam logic [MODE_W-1:0] MODE_HOST = 3'h4;
  localparam logic [MODE_W-1:0] MODE_IDX_HOST = 3'h5;
  localparam logic [MODE_W-1:0] MODE_CMP_HOST = 3'h6;
  localparam logic [MODE_W-1:0] MODE_ALL = 3'h7;
  // Least gaps the outside keeps between repeated resets
  localparam int CLK_HZ = 50_000_000;
  localparam int IDX_GAP_US = 100;
  localparam int EXT_GAP_US = 1000;
  localparam int IDX_GAP_CYC = (IDX_GAP_US * (CLK_HZ / 1_000_000));
  localparam int EXT_GAP_CYC = (EXT_GAP_US * (CLK_HZ / 1_000_000));
endpackage : cnt_pkg

/* File: src/counter_preset_reset_readback.sv */
// Present value counter with reset modes, preset, compare loads and readback
`timescale 1ns/1ps
module counter_preset_reset_readback
  import cnt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WORD_W-1:0] setting_data_low,
  input wire logic [WORD_W-1:0] setting_data_high,
  input wire logic [WORD_W-1:0] counter_control_word,
  output logic [WORD_W-1:0] count_readback_low,
  output logic [WORD_W-1:0] count_readback_high,
  input wire logic index_pin,
  input wire logic ext_pin,
  input wire logic count_pulse,
  input wire logic count_up,
  output logic signed [VAL_W-1:0] present_value,
  output logic signed [VAL_W-1:0] compare_value1,
  output logic signed [VAL_W-1:0] compare_value2,
  output logic [COND_W-1:0] compare_cond1,
  output logic [COND_W-1:0] compare_cond2,
  output logic range_error,
  output logic compare_out1,
  output logic compare_out2
);
  logic idx_s1_r;
  logic idx_s2_r;
  logic idx_prev_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic [WORD_W-1:0] ctl_prev_r;
  logic signed [VAL_W-1:0] pv_r;
  logic signed [VAL_W-1:0] pv_nxt;
  logic signed [VAL_W-1:0] sv1_r;
  logic signed [VAL_W-1:0] sv2_r;
  logic [COND_W-1:0] cond1_r;
  logic [COND_W-1:0] cond2_r;
  logic halted_r;
  logic halted_nxt;
  logic pending_r;
  logic [WORD_W-1:0] rb_low_r;
  logic [WORD_W-1:0] rb_high_r;
  logic out1_r;
  logic out2_r;

  logic idx_rise;
  logic host_rst;
  logic hex_fmt;
  logic [MODE_W-1:0] mode;
  logic fulfil;
  logic pv_load_edge;
  logic sv1_load_edge;
  logic sv2_load_edge;
  logic rb_edge;
  logic hit1;
  logic hit2;
  logic cmp_any;

  logic [2*WORD_W-1:0] enc_bcd;
  logic [2*WORD_W-1:0] dec_bcd_in;
  logic signed [VAL_W-1:0] dec_bin;
  logic signed [VAL_W-1:0] set_value;
  logic signed [VAL_W-1:0] hex_value;

  // Pins pass two flip-flops; the index edge detector compares the second stage with a third flop, idx_prev_r
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_s1_r <= 1'b0;
      idx_s2_r <= 1'b0;
      idx_prev_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      idx_s1_r <= index_pin;
      idx_s2_r <= idx_s1_r;
      idx_prev_r <= idx_s2_r;
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
    end
  end

  assign idx_rise = idx_s2_r & ~idx_prev_r;
  assign host_rst = counter_control_word[CW_HOST_RESET];
  assign hex_fmt = counter_control_word[CW_FMT_HEX];
  assign mode = counter_control_word[CW_MODE_HI:CW_MODE_LO];

  // Command bits are sampled on the same clock as the host words
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_prev_r <= WORD_RESET;
    end else begin
      ctl_prev_r <= counter_control_word;
    end
  end

  // Rising edges of the load and readback commands
  assign pv_load_edge = counter_control_word[CW_PV_LOAD] & ~ctl_prev_r[CW_PV_LOAD];
  assign sv1_load_edge = counter_control_word[CW_SET1_LOAD] & ~ctl_prev_r[CW_SET1_LOAD];
  assign sv2_load_edge = counter_control_word[CW_SET2_LOAD] & ~ctl_prev_r[CW_SET2_LOAD];
  assign rb_edge = counter_control_word[CW_READBACK] & ~ctl_prev_r[CW_READBACK];

  assign cmp_any = hit1 | hit2;

  // Reset condition per mode; index modes need the index edge to come last
  always_comb begin
    case (mode)
      MODE_IDX: fulfil = idx_rise;
      MODE_EXT: fulfil = ext_s2_r;
      MODE_IDX_EXT: fulfil = idx_rise & ext_s2_r;
      MODE_HOST: fulfil = host_rst;
      MODE_IDX_HOST: fulfil = idx_rise & host_rst;
      MODE_CMP_HOST: fulfil = cmp_any & host_rst;
      MODE_ALL: fulfil = idx_rise & ext_s2_r & host_rst;
      default: fulfil = 1'b0;
    endcase
  end

  // A fulfilled condition waits for the next count event; a new one wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (fulfil) begin
      pending_r <= 1'b1;
    end else if (count_pulse | pv_load_edge) begin
      pending_r <= 1'b0;
    end
  end

  // Setting word decode: hex keeps the low 24 bits, BCD goes through the codec
  assign hex_value = $signed({setting_data_high[HEX_HIGH_W-1:0], setting_data_low});
  always_comb begin
    if (pv_load_edge) begin
      dec_bcd_in = {setting_data_high, setting_data_low};
    end else begin
      dec_bcd_in = {(setting_data_high[SV_BCD_SIGN] ? SIGN_NEG : SIGN_POS),
                    setting_data_high[11:0], setting_data_low};
    end
    set_value = hex_fmt ? hex_value : dec_bin;
  end

  bcd_codec u_codec (
    .bin_in(pv_r),
    .bcd_out(enc_bcd),
    .bcd_in(dec_bcd_in),
    .bin_out(dec_bin)
  );

  // Present value: preset first, then pending reset on a count, then counting
  always_comb begin
    pv_nxt = pv_r;
    halted_nxt = halted_r;
    if (pv_load_edge) begin
      pv_nxt = set_value;
      halted_nxt = 1'b0;
    end else if (count_pulse && pending_r) begin
      pv_nxt = PV_RESET;
      halted_nxt = 1'b0;
    end else if (count_pulse && !halted_r) begin
      if (count_up) begin
        if (pv_r == PV_MAX) begin
          halted_nxt = 1'b1;
        end else begin
          pv_nxt = pv_r + 24'sd1;
        end
      end else begin
        if (pv_r == PV_MIN) begin
          halted_nxt = 1'b1;
        end else begin
          pv_nxt = pv_r - 24'sd1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pv_r <= PV_RESET;
      halted_r <= 1'b0;
    end else begin
      pv_r <= pv_nxt;
      halted_r <= halted_nxt;
    end
  end

  // Compare loads take value and condition together, at any time
  always_ff @(posedge clk) begin
    if (rst) begin
      sv1_r <= PV_RESET;
      cond1_r <= COND_RESET;
    end else if (sv1_load_edge) begin
      sv1_r <= set_value;
      cond1_r <= setting_data_high[SV_COND_HI:SV_COND_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sv2_r <= PV_RESET;
      cond2_r <= COND_RESET;
    end else if (sv2_load_edge) begin
      sv2_r <= set_value;
      cond2_r <= setting_data_high[SV_COND_HI:SV_COND_LO];
    end
  end

  assign hit1 = (cond1_r == COND_GE) ? (pv_r >= sv1_r) : (pv_r <= sv1_r);
  assign hit2 = (cond2_r == COND_GE) ? (pv_r >= sv2_r) : (pv_r <= sv2_r);

  // External outputs gated by their enable bits
  always_ff @(posedge clk) begin
    if (rst) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end else begin
      out1_r <= hit1 & counter_control_word[CW_OUT1_EN];
      out2_r <= hit2 & counter_control_word[CW_OUT2_EN];
    end
  end

  // Readback holds the value of the command cycle in the current format
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_low_r <= WORD_RESET;
      rb_high_r <= WORD_RESET;
    end else if (rb_edge) begin
      if (hex_fmt) begin
        rb_low_r <= pv_r[WORD_W-1:0];
        rb_high_r <= {{HEX_HIGH_W{1'b0}}, pv_r[VAL_W-1:WORD_W]};
      end else begin
        rb_low_r <= enc_bcd[WORD_W-1:0];
        rb_high_r <= enc_bcd[2*WORD_W-1:WORD_W];
      end
    end
  end

  assign count_readback_low = rb_low_r;
  assign count_readback_high = rb_high_r;
  assign present_value = pv_r;
  assign compare_value1 = sv1_r;
  assign compare_value2 = sv2_r;
  assign compare_cond1 = cond1_r;
  assign compare_cond2 = cond2_r;
  assign range_error = halted_r;
  assign compare_out1 = out1_r;
  assign compare_out2 = out2_r;
endmodule : counter_preset_reset_readback
